// [addr_decoder_asserts.sv]
// Concurrent checks on the system address decoder ports
`timescale 1ns/1ps
`default_nettype none
module addr_decoder_asserts
	import addr_decoder_pkg::*;
(
	// Clock, reset and address phase
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HREADY,
	input wire logic        vectRemap,
	input wire logic        protEnable,
	// Decode results
	input wire slave_e      slaveSel,
	input wire logic [6:0]  ahbSlot,
	input wire logic [5:0]  apbSlot,
	input wire logic        first_timer_slot,
	input wire logic        usbSlot,
	input wire logic        decodeErr,
	input wire logic        memManageFault
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Active transfer taken with protection off
	sequence s_open;
		HREADY && HTRANS[1] && !protEnable;
	endsequence
	a_apb_slot_index: assert property (HREADY |=> apbSlot == $past(HADDR[19:14]))
		else $error("apbSlot not taken from address");
	a_ahb_slot_index: assert property (HREADY |=> ahbSlot == $past(HADDR[20:14]))
		else $error("ahbSlot not taken from address");
	a_timer_slot_hit: assert property (s_open ##0 HADDR[31:14] == 18'h10001 |=> first_timer_slot)
		else $error("first timer slot missed");
	a_usb_slot_hit: assert property (s_open ##0 HADDR[31:14] == 18'h14003
		|=> usbSlot && slaveSel == SLV_AHBP)
		else $error("usb slot missed");
	a_ppb_route: assert property (s_open ##0 HADDR[31:20] == 12'hE00 |=> slaveSel == SLV_PPB)
		else $error("private bus not selected");
	a_vect_remap: assert property (s_open ##0 vectRemap && HADDR < 32'h100 |=> slaveSel == SLV_VECT)
		else $error("vector remap ignored");
	a_idle_none: assert property (HREADY && !HTRANS[1] |=> slaveSel == SLV_NONE && !decodeErr)
		else $error("idle transfer selected a slave");
	// Only just after a taken phase; a stall keeps the old fault standing
	a_fault_blocks: assert property ($past(HREADY) && memManageFault
		|-> slaveSel == SLV_NONE && $past(protEnable && HTRANS[1]))
		else $error("fault without blocking");
	a_err_alone: assert property (decodeErr |-> slaveSel == SLV_NONE && !memManageFault)
		else $error("error with a slave selected");
endmodule // addr_decoder_asserts
bind system_address_decoder addr_decoder_asserts u_asserts (.*);
`default_nettype wire

// [addr_decoder_cfg.svh]
// Address map constants for the system address decoder
`ifndef ADDR_DECODER_CFG_SVH
`define ADDR_DECODER_CFG_SVH

`define FLASH_BASE      32'h0000_0000
`define FLASH_END       32'h0008_0000
`define VECT_END        32'h0000_0100
`define LSRAM_BASE      32'h1000_0000
`define LSRAM_END       32'h1000_8000
`define BROM_BASE       32'h1FFF_0000
`define BROM_END        32'h1FFF_2000
`define XSRAM_BASE      32'h2007_C000
`define XSRAM_END       32'h2008_4000
`define FGPIO_BASE      32'h2009_C000
`define FGPIO_END       32'h200A_0000
`define SBB_BASE        32'h2200_0000
`define SBB_END         32'h2400_0000
`define FIRST_APB_GROUP_BASE       32'h4000_0000
`define SECOND_APB_GROUP_BASE       32'h4008_0000
`define APB_END         32'h4010_0000
`define PBB_BASE        32'h4200_0000
`define PBB_END         32'h4400_0000
`define AHBP_BASE       32'h5000_0000
`define AHBP_END        32'h5020_0000
`define PPB_BASE        32'hE000_0000
`define PPB_END         32'hE010_0000
`define WDT_ADDR        32'h4000_0000
`define TMR0_ADDR       32'h4000_4000
`define TMR1_ADDR       32'h4000_8000
`define USB_ADDR        32'h5000_C000
`define SLOT_LSB        14
`define AHB_SLOT_W      7
`define APB_SLOT_W      6
`define NUM_REGIONS     8
`define NUM_SUBREG      8
`define PROT_CFG_W      2

`endif

// [addr_decoder_pkg.sv]
// Types shared by the system address decoder
package addr_decoder_pkg;

	// Slave port selected by the decoder
	typedef enum logic [3:0] {
		SLV_NONE  = 4'h0,
		SLV_FLASH = 4'h1,
		SLV_VECT  = 4'h2,
		SLV_LSRAM = 4'h3,
		SLV_BROM  = 4'h4,
		SLV_XSRAM = 4'h5,
		SLV_FGPIO = 4'h6,
		SLV_SBB   = 4'h7,
		SLV_FIRST_APB_GROUP  = 4'h8,
		SLV_SECOND_APB_GROUP  = 4'h9,
		SLV_PBB   = 4'hA,
		SLV_AHBP  = 4'hB,
		SLV_PPB   = 4'hC
	} slave_e;

	// Region access policy
	typedef enum logic [1:0] {
		PROT_NONE = 2'h0,
		PROT_RO   = 2'h1,
		PROT_RW   = 2'h2
	} prot_e;

endpackage

// [ahb_master_model.sv]
// Behavioural AHB-Lite master driving the decoder address phase
`timescale 1ns/1ps
`default_nettype none
module ahb_master_model (
	// Address phase toward the decoder
	output logic [31:0] HADDR,
	output logic [1:0]  HTRANS,
	output logic        HWRITE,
	output logic        HREADY
);
	// Idle bus at time zero
	initial begin
		HADDR = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HREADY = 1'b1;
	end
	// One phase, held until the next call; rdy low stalls it
	task automatic request(input logic [31:0] a, input logic w, input logic rdy);
		HADDR = a;
		HTRANS = 2'h2;
		HWRITE = w;
		HREADY = rdy;
	endtask
	// Released bus: address inverted so a stale value is never reused
	task automatic idle();
		HADDR = ~HADDR;
		HTRANS = 2'h0;
		HREADY = 1'b1;
	endtask
endmodule // ahb_master_model
`default_nettype wire

// [region_protection_checker.sv]
// Region protection checker with eight regions of eight subregions
`timescale 1ns/1ps
`default_nettype none
`include "addr_decoder_cfg.svh"
module region_protection_checker
	import addr_decoder_pkg::*;
(
	// Access under test
	input  wire logic [31:0] addr,
	input  wire logic        write,
	input  wire logic        checkEn,
	// Region setup, one lane per region
	input  wire logic [`NUM_REGIONS-1:0]       regionEn,
	input  wire logic [`NUM_REGIONS*32-1:0]    regionBase,
	input  wire logic [`NUM_REGIONS*5-1:0]     regionSizeLog2,
	input  wire logic [`NUM_REGIONS*8-1:0]     subregionDis,
	input  wire logic [`NUM_REGIONS*2-1:0]     regionPerm,
	// Verdict
	output logic                               blocked
);

	logic [`NUM_REGIONS-1:0] hit;
	logic [`NUM_REGIONS-1:0] allow;

	// Match each region; highest numbered hit decides, as on the core
	always_comb begin
		logic [31:0] mask;
		logic [4:0]  sz;
		logic [2:0]  sub;
		logic [1:0]  perm;
		mask = 32'h0;
		sz   = 5'h0;
		sub  = 3'h0;
		perm = 2'h0;
		for (int r = 0; r < `NUM_REGIONS; r++) begin
			sz   = regionSizeLog2[r*5 +: 5];
			mask = 32'hFFFF_FFFF << sz;
			sub  = 3'((addr >> (sz - 5'd3)) & 32'h7);
			perm = regionPerm[r*2 +: 2];
			hit[r] = regionEn[r] && ((addr & mask) == (regionBase[r*32 +: 32] & mask))
				&& !subregionDis[r*8 + int'(sub)];
			allow[r] = (perm == PROT_RW) || ((perm == PROT_RO) && !write);
		end
	end

	// No hit, or winner forbids it: blocked
	always_comb begin
		logic ok;
		logic any;
		ok  = 1'b0;
		any = 1'b0;
		for (int r = 0; r < `NUM_REGIONS; r++) begin
			if (hit[r]) begin
				any = 1'b1;
				ok  = allow[r];
			end
		end
		blocked = checkEn && (!any || !ok);
	end

endmodule // region_protection_checker
`default_nettype wire

// [system_address_decoder.sv]
// System address decoder: slave select, slot index, protection fault
`timescale 1ns/1ps
`default_nettype none
`include "addr_decoder_cfg.svh"
module system_address_decoder
	import addr_decoder_pkg::*;
(
	// Clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          sys_rst,
	// AHB-Lite address phase from a master
	input  wire logic [31:0]                   HADDR,
	input  wire logic [1:0]                    HTRANS,
	input  wire logic                          HWRITE,
	input  wire logic                          HREADY,
	// Vector remap and protection setup
	input  wire logic                          vectRemap,
	input  wire logic                          protEnable,
	input  wire logic [`NUM_REGIONS-1:0]       regionEn,
	input  wire logic [`NUM_REGIONS*32-1:0]    regionBase,
	input  wire logic [`NUM_REGIONS*5-1:0]     regionSizeLog2,
	input  wire logic [`NUM_REGIONS*8-1:0]     subregionDis,
	input  wire logic [`NUM_REGIONS*2-1:0]     regionPerm,
	// Data-phase decode results
	output slave_e                             slaveSel,
	output logic [`AHB_SLOT_W-1:0]             ahbSlot,
	output logic [`APB_SLOT_W-1:0]             apbSlot,
	output logic                               watchdog_slot,
	output logic                               first_timer_slot,
	output logic                               second_timer_slot,
	output logic                               usbSlot,
	output logic                               xsramBlock,
	output logic                               decodeErr,
	output logic                               memManageFault
);

	//////////////////////////////////////////////////////////////////////////
	// Range helper used for every window except the vectors
	function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		inRange = (a >= lo) && (a < hi);
	endfunction

	wire logic active = HTRANS[1] && HREADY;

	// Window hits; each master has its own decoder, so no arbitration here
	wire logic hitVect  = (HADDR < `VECT_END) && vectRemap;
	// Flash gives way to the remapped vectors so the unique case sees one hit
	wire logic hitFlash = inRange(HADDR, `FLASH_BASE, `FLASH_END) && !hitVect;
	wire logic hitLsram = inRange(HADDR, `LSRAM_BASE, `LSRAM_END);
	wire logic hitBrom  = inRange(HADDR, `BROM_BASE, `BROM_END);
	wire logic hitXsram = inRange(HADDR, `XSRAM_BASE, `XSRAM_END);
	wire logic hitFgpio = inRange(HADDR, `FGPIO_BASE, `FGPIO_END);
	wire logic hitSbb   = inRange(HADDR, `SBB_BASE, `SBB_END);
	wire logic hitApb0  = inRange(HADDR, `FIRST_APB_GROUP_BASE, `SECOND_APB_GROUP_BASE);
	wire logic hitApb1  = inRange(HADDR, `SECOND_APB_GROUP_BASE, `APB_END);
	wire logic hitPbb   = inRange(HADDR, `PBB_BASE, `PBB_END);
	wire logic hitAhbp  = inRange(HADDR, `AHBP_BASE, `AHBP_END);
	wire logic hitPpb   = inRange(HADDR, `PPB_BASE, `PPB_END);

	// Priority: vector remap overrides flash in the bottom 256 bytes
	slave_e selD;
	always_comb begin
		unique case (1'b1)
			hitVect:  selD = SLV_VECT;
			hitFlash: selD = SLV_FLASH;
			hitLsram: selD = SLV_LSRAM;
			hitBrom:  selD = SLV_BROM;
			hitXsram: selD = SLV_XSRAM;
			hitFgpio: selD = SLV_FGPIO;
			hitSbb:   selD = SLV_SBB;
			hitApb0:  selD = SLV_FIRST_APB_GROUP;
			hitApb1:  selD = SLV_SECOND_APB_GROUP;
			hitPbb:   selD = SLV_PBB;
			hitAhbp:  selD = SLV_AHBP;
			hitPpb:   selD = SLV_PPB;
			default:  selD = SLV_NONE;
		endcase
	end

	// Slot index bits right above the 16 kB offset
	wire logic [`AHB_SLOT_W-1:0] ahbSlotD = HADDR[`SLOT_LSB +: `AHB_SLOT_W];
	wire logic [`APB_SLOT_W-1:0] apbSlotD = HADDR[`SLOT_LSB +: `APB_SLOT_W];
	wire logic [31:0]            slotBase = {HADDR[31:`SLOT_LSB], 14'h0};

	// Named slots on the first APB group and the AHB area; xsram block bit from HADDR[14] on any address
	wire logic wdtD  = hitApb0 && (slotBase == `WDT_ADDR);
	wire logic tmr0D = hitApb0 && (slotBase == `TMR0_ADDR);
	wire logic tmr1D = hitApb0 && (slotBase == `TMR1_ADDR);
	wire logic usbD  = hitAhbp && (slotBase == `USB_ADDR);
	wire logic xblkD = HADDR[`SLOT_LSB];

	//////////////////////////////////////////////////////////////////////////
	// Protection check on the same address
	logic blocked;
	region_protection_checker uChecker (
		.addr           (HADDR),
		.write          (HWRITE),
		.checkEn        (protEnable),
		.regionEn       (regionEn),
		.regionBase     (regionBase),
		.regionSizeLog2 (regionSizeLog2),
		.subregionDis   (subregionDis),
		.regionPerm     (regionPerm),
		.blocked        (blocked)
	);

	// Blocked access selects nothing; fault raised instead
	wire logic faultD = active && blocked;
	wire logic errD   = active && !blocked && (selD == SLV_NONE);

	//////////////////////////////////////////////////////////////////////////
	// Register into data phase; idle selects SLV_NONE with no flags except xsramBlock, taken from HADDR[14] on any phase
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			slaveSel          <= SLV_NONE;
			ahbSlot           <= '0;
			apbSlot           <= '0;
			watchdog_slot     <= 1'b0;
			first_timer_slot  <= 1'b0;
			second_timer_slot <= 1'b0;
			usbSlot           <= 1'b0;
			xsramBlock        <= 1'b0;
			decodeErr         <= 1'b0;
			memManageFault    <= 1'b0;
		end else if (HREADY) begin
			slaveSel          <= (active && !blocked) ? selD : SLV_NONE;
			ahbSlot           <= ahbSlotD;
			apbSlot           <= apbSlotD;
			watchdog_slot     <= active && !blocked && wdtD;
			first_timer_slot  <= active && !blocked && tmr0D;
			second_timer_slot <= active && !blocked && tmr1D;
			usbSlot           <= active && !blocked && usbD;
			xsramBlock        <= xblkD;
			decodeErr         <= errD;
			memManageFault    <= faultD;
		end
	end

endmodule // system_address_decoder
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the system address decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import addr_decoder_pkg::*;
	logic sys_clk, sys_rst, vectRemap, protEnable, HWRITE, HREADY;
	logic [31:0] HADDR;
	logic [1:0] HTRANS;
	logic [7:0] regionEn;
	logic [255:0] regionBase;
	logic [39:0] regionSizeLog2;
	logic [63:0] subregionDis;
	logic [15:0] regionPerm;
	slave_e slaveSel;
	logic [6:0] ahbSlot;
	logic [5:0] apbSlot;
	logic watchdog_slot, first_timer_slot, second_timer_slot, usbSlot;
	logic xsramBlock, decodeErr, memManageFault;
	int fails, checksDone;
	localparam logic [31:0] LO [11] = '{32'h0, 32'h10000000, 32'h1FFF0000, 32'h2007C000,
		32'h2009C000, 32'h22000000, 32'h40000000, 32'h40080000, 32'h42000000, 32'h50000000,
		32'hE0000000};
	localparam logic [31:0] HI [11] = '{32'h80000, 32'h10008000, 32'h1FFF2000, 32'h20084000,
		32'h200A0000, 32'h24000000, 32'h40080000, 32'h40100000, 32'h44000000, 32'h50200000,
		32'hE0100000};
	localparam slave_e SL [11] = '{SLV_FLASH, SLV_LSRAM, SLV_BROM, SLV_XSRAM, SLV_FGPIO, SLV_SBB,
		SLV_FIRST_APB_GROUP, SLV_SECOND_APB_GROUP, SLV_PBB, SLV_AHBP, SLV_PPB};
	localparam logic [31:0] DIR [19] = '{32'h7FFFC, 32'h80000, 32'h10007FFC, 32'h10008000,
		32'h1FFF2000, 32'h20080000, 32'h20084000, 32'h23FFFFFC, 32'h40000000, 32'h40004000,
		32'h40008000, 32'h40080000, 32'h400FFFFC, 32'h40100000, 32'h5000C000, 32'h501FFFFC,
		32'h50200000, 32'hE00FFFFC, 32'hE0100000};
	localparam logic [31:0] PA [7] = '{32'h40000000, 32'h40000000, 32'h40002000, 32'h40008000,
		32'h10000004, 32'h1FFF0000, 32'h4000FFFC};
	localparam logic [6:0] PW = 7'h12;
	localparam logic [6:0] PF = 7'h26;

	ahb_master_model u_master (.*);
	system_address_decoder u_system_address_decoder (.*);

	// Clock at 100 MHz
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Expected slave from the map windows; remap wins on the vectors
	function automatic slave_e expSlave(input logic [31:0] a, input logic rm);
		expSlave = SLV_NONE;
		for (int i = 0; i < 11; i++)
			if (a >= LO[i] && a < HI[i])
				expSlave = SL[i];
		if (rm && a < 32'h100)
			expSlave = SLV_VECT;
	endfunction
	task automatic chkSlave(input string n, input slave_e e, input slave_e g);
		checksDone++;
		if (e !== g) begin
			fails++;
			$display("ERROR %s expected %s seen %s", n, e.name(), g.name());
		end
	endtask
	task automatic chkVal(input string n, input logic [7:0] e, input logic [7:0] g);
		checksDone++;
		if (e !== g) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// One taken transfer, checked one cycle later; f marks a blocked one
	task automatic run(input logic [31:0] a, input logic w, input logic f);
		slave_e e;
		e = f ? SLV_NONE : expSlave(a, vectRemap);
		u_master.request(a, w, 1'b1);
		@(posedge sys_clk);
		#1;
		chkSlave("slaveSel", e, slaveSel);
		chkVal("apbSlot", {2'h0, a[19:14]}, {2'h0, apbSlot});
		chkVal("ahbSlot", {1'h0, a[20:14]}, {1'h0, ahbSlot});
		chkVal("decodeErr", {7'h0, !f && e == SLV_NONE}, {7'h0, decodeErr});
		chkVal("fault", {7'h0, f}, {7'h0, memManageFault});
		chkVal("slotHits", {4'h0, {4{!f}} & {a[31:14] == 18'h10000, a[31:14] == 18'h10001,
			a[31:14] == 18'h10002, a[31:14] == 18'h14003}}, {4'h0, watchdog_slot,
			first_timer_slot, second_timer_slot, usbSlot});
		chkVal("xsramBlock", {7'h0, a[14]}, {7'h0, xsramBlock});
	endtask
	task automatic give_verdict();
		$display("checks %0d fails %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog: the tests need about 355 cycles
	initial begin
		#50000;
		fails++;
		give_verdict();
	end
	// Main sequence
	initial begin
		logic [31:0] a;
		int k;
		sys_rst = 1'b1;
		vectRemap = 1'b0;
		protEnable = 1'b0;
		regionEn = 8'h03;
		regionBase = {192'h0, 32'h10000000, 32'h40000000};
		regionSizeLog2 = {30'h0, 5'h0F, 5'h10};
		subregionDis = 64'h2;
		regionPerm = {12'h0, 2'h2, 2'h1};
		a = $urandom(59);
		repeat (10) @(posedge sys_clk);
		#1 sys_rst = 1'b0;
		foreach (LO[i]) run(LO[i], 1'b0, 1'b0);
		foreach (DIR[i]) run(DIR[i], 1'b1, 1'b0);
		vectRemap = 1'b1;
		run(32'hFC, 1'b0, 1'b0);
		run(32'h100, 1'b0, 1'b0);
		$display("test map corners done");
		// Random windows, offsets and remap
		repeat (300) begin
			k = $urandom_range(10);
			a = $urandom_range(1) ? LO[k] + ($urandom % (HI[k] - LO[k])) : $urandom;
			vectRemap = $urandom_range(1);
			run(a, $urandom_range(1), 1'b0);
		end
		$display("test random done");
		// Stalled phase must leave the last answer standing
		run(32'h40008000, 1'b0, 1'b0);
		u_master.request(32'h5000C000, 1'b0, 1'b0);
		repeat (3) @(posedge sys_clk);
		#1 chkSlave("stall", SLV_FIRST_APB_GROUP, slaveSel);
		u_master.idle();
		@(posedge sys_clk);
		#1 chkSlave("idle", SLV_NONE, slaveSel);
		$display("test stall done");
		protEnable = 1'b1;
		foreach (PA[i]) run(PA[i], PW[i], PF[i]);
		regionPerm = 16'h0;
		run(32'h40000000, 1'b0, 1'b1);
		$display("test protection done");
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
